/* File: core/van_line_bit_timing.v */
// Purpose: VAN line layer: prescaler, input selection, line coding, SOF and bus access
// Assumes: osc_in and line inputs are synchronous to clk_sys_in
// Notes:   APB slave, zero wait states, answers in the access cycle
// Contract
// [R1] Timeslot clock is osc over sixteen times n
// [R2] Codes select powers of two, or times 1.5
// [R3] Clock output copies oscillator input, not inverted
// [R4] Three line inputs, one output, selectable
// [R5] Auto selection picks the most reliable input
// [R6] Recessive high, dominant low, own transmission heard
// [R7] Bitwise arbitration through the whole transmission
// [R8] Pulsed dominant is two-clock low pulse
// [R9] Pulsed receiver decodes edges, not levels
// [R10] Pulsed mode forces reception on input zero
// [R11] Pulsed mode loops transmitter back internally
// [R12] Timeslot is sixteen prescaled clocks
// [R13] Frame opens with start-of-frame sequence
// [R14] Only autonomous modules send start-of-frame
// [R15] Resync bit clock during received preamble
// [R16] Data follows the complete start sequence
// [R17] Enhanced Manchester: three NRZ, one Manchester
// [R18] Bus free after quiet EOF plus IFS
// [R19] IFS 64 clocks; zero accepted on receive
// [R20] Autonomous sends SOF; synchronous waits for preamble
// [R21] Configuration changes take effect between frames
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "van_line_consts.vh"

module van_line_bit_timing (
	input  wire        clk_sys_in,
	input  wire        reset_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [7:0]  paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	input  wire        osc_in,
	output reg         osc_drive_out,
	output reg         buffered_clock_out,
	output reg         timeslot_clock_out,
	input  wire        line_input_zero_in,
	input  wire        line_input_one_in,
	input  wire        line_input_two_in,
	output reg         line_tx_out
);

	localparam ST_IDLE   = 2'h0;
	localparam ST_SOF_TX = 2'h1;
	localparam ST_SOF_RX = 2'h2;
	localparam ST_FRAME  = 2'h3;

	function [8:0] edge_period;
		input [3:0] code;
		begin
			if (code[3])
				edge_period = 9'd3 << code[2:0];
			else
				edge_period = 9'd2 << code[2:0];
		end
	endfunction

	reg  [8:0]  ctrl_reg;
	reg  [31:0] tx_data_reg;
	reg  [5:0]  tx_len_reg;
	reg  [3:0]  div_act_reg;
	reg  [1:0]  sel_act_reg;
	reg         pulsed_act_reg;
	reg  [1:0]  type_act_reg;
	reg  [1:0]  best_reg;
	reg  [1:0]  state_reg;
	reg         osc_q_reg;
	reg  [8:0]  div_cnt_reg;
	reg  [3:0]  slot_cnt_reg;
	reg         rx_raw_reg;
	reg         rx_prev_reg;
	reg  [4:0]  hold_cnt_reg;
	reg         rx_sample_reg;
	reg  [7:0]  rec_cnt_reg;
	reg  [3:0]  ts_cnt_reg;
	reg  [1:0]  gp_reg;
	reg         half_reg;
	reg         tx_bit_reg;
	reg         tx_active_reg;
	reg         tx_pending_reg;
	reg         sync_armed_reg;
	reg  [31:0] tx_shift_reg;
	reg  [5:0]  tx_left_reg;
	reg  [31:0] rx_shift_reg;
	reg  [5:0]  rx_cnt_reg;
	reg  [31:0] rx_data_reg;
	reg  [5:0]  rx_count_reg;
	reg         arb_lost_reg;
	reg         tx_done_reg;
	reg         rx_done_reg;
	reg         line_tx_next;
	reg  [31:0] rdata_next;

	wire [2:0]  lines = {line_input_two_in, line_input_one_in, line_input_zero_in};
	wire        setup = psel_in & ~penable_in;
	wire        wr_en = psel_in & penable_in & pready_out & pwrite_in;
	wire        wr_cmd = wr_en && paddr_in == `OFS_CMD;
	wire        wr_stat = wr_en && paddr_in == `OFS_STATUS;
	wire        start_cmd = wr_cmd & pwdata_in[`CMD_START_BIT];
	wire        abort_cmd = wr_cmd & pwdata_in[`CMD_ABORT_BIT];
	wire        osc_edge = osc_in ^ osc_q_reg;
	wire        tick = osc_edge && div_cnt_reg == edge_period(div_act_reg) - 9'd1;
	wire        ts_end = tick && slot_cnt_reg == 4'hf;
	wire        sample_pt = tick && slot_cnt_reg == `SAMPLE_SLOT;
	wire [1:0]  sel_used = pulsed_act_reg ? 2'h0 : (sel_act_reg == `SEL_AUTO ? best_reg : sel_act_reg);
	wire        rx_level = pulsed_act_reg ? hold_cnt_reg == 5'd0 : rx_raw_reg;
	wire        rx_fall = rx_prev_reg & ~rx_raw_reg;
	wire        rx_edge = rx_prev_reg ^ rx_raw_reg;
	wire        bus_free = rec_cnt_reg >= `EOF_TS + `IFS_TS;
	wire        eof_seen = rx_sample_reg && rec_cnt_reg >= `EOF_TS - 1;
	wire        data_slot = !(gp_reg == 2'h3 && !half_reg);
	wire        majority = (lines[0] & lines[1]) | (lines[1] & lines[2]) | (lines[0] & lines[2]);
	wire [23:0] err_all;
	wire [9:0]  sof_pattern = `SOF_PATTERN;

	// Each input is scored against the other two and against the bit timing
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : diag
			reg [7:0] err_cnt_reg;
			reg [3:0] spacing_reg;
			reg       last_reg;
			wire      in_edge = lines[gi] ^ last_reg;
			wire      bad = (sample_pt && lines[gi] != majority) ||
			                (in_edge && spacing_reg < `MIN_EDGE_TICKS);
			always @(posedge clk_sys_in) begin
				if (reset_in) begin
					err_cnt_reg <= 8'h00;
					spacing_reg <= 4'hf;
					last_reg    <= 1'b1;
				end else begin
					last_reg <= lines[gi];
					if (in_edge)
						spacing_reg <= 4'h0;
					else if (tick && spacing_reg != 4'hf)
						spacing_reg <= spacing_reg + 4'h1;
					if (state_reg == ST_FRAME && ts_end && eof_seen)
						err_cnt_reg <= {1'b0, err_cnt_reg[7:1]}; // [R5]
					else if (bad && err_cnt_reg != 8'hff)
						err_cnt_reg <= err_cnt_reg + 8'h01; // [R5]
				end
			end
			assign err_all[gi*8 +: 8] = err_cnt_reg;
		end
	endgenerate

	always @* begin
		if (pulsed_act_reg)
			line_tx_next = tx_bit_reg | (slot_cnt_reg >= `PULSE_TICKS); // [R8]
		else
			line_tx_next = tx_bit_reg; // [R6]
	end

	always @* begin
		case (paddr_in)
		`OFS_CTRL:     rdata_next = {23'h000000, ctrl_reg};
		`OFS_TX_DATA:  rdata_next = tx_data_reg;
		`OFS_TX_LEN:   rdata_next = {26'h0000000, tx_len_reg};
		`OFS_STATUS:   rdata_next = {21'h000000, state_reg, sel_used, state_reg != ST_IDLE, bus_free,
		                             tx_active_reg, tx_pending_reg, rx_done_reg, tx_done_reg, arb_lost_reg};
		`OFS_RX_DATA:  rdata_next = rx_data_reg;
		`OFS_RX_COUNT: rdata_next = {26'h0000000, rx_count_reg};
		`OFS_DIAG:     rdata_next = {8'h00, err_all};
		default:       rdata_next = 32'h00000000;
		endcase
	end

	// Register slave: data is prepared in setup so the access cycle answers at once
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			ctrl_reg    <= `CTRL_RESET;
			tx_data_reg <= 32'h00000000;
			tx_len_reg  <= 6'h00;
			prdata_out  <= 32'h00000000;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= setup;
			pslverr_out <= setup && (paddr_in[1:0] != 2'h0 || paddr_in > `OFS_DIAG);
			if (setup)
				prdata_out <= rdata_next;
			if (wr_en && paddr_in == `OFS_CTRL)
				ctrl_reg <= pwdata_in[8:0]; // [R21]
			if (wr_en && paddr_in == `OFS_TX_DATA)
				tx_data_reg <= pwdata_in;
			if (wr_en && paddr_in == `OFS_TX_LEN)
				tx_len_reg <= pwdata_in[5:0];
		end
	end

	// Pins and prescaler
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			osc_q_reg          <= 1'b0;
			osc_drive_out      <= 1'b1;
			buffered_clock_out <= 1'b0;
			timeslot_clock_out <= 1'b0;
			line_tx_out        <= 1'b1;
			div_cnt_reg        <= 9'h000;
			slot_cnt_reg       <= 4'h0;
		end else begin
			osc_q_reg          <= osc_in;
			osc_drive_out      <= ~osc_in;
			buffered_clock_out <= osc_in; // [R3]
			timeslot_clock_out <= ts_end; // [R1]
			line_tx_out        <= line_tx_next; // [R4]
			if (state_reg == ST_SOF_RX && rx_edge) begin
				div_cnt_reg  <= 9'h000; // [R15]
				slot_cnt_reg <= 4'h0; // [R15]
			end else if (tick) begin
				div_cnt_reg  <= 9'h000;
				slot_cnt_reg <= slot_cnt_reg + 4'h1; // [R12]
			end else if (osc_edge) begin
				div_cnt_reg <= div_cnt_reg + 9'h001; // [R1] [R2]
			end
		end
	end

	// Receive path; pulsed mode stretches each falling edge into a dominant timeslot
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			rx_raw_reg    <= 1'b1;
			rx_prev_reg   <= 1'b1;
			hold_cnt_reg  <= 5'h00;
			rx_sample_reg <= 1'b1;
		end else begin
			if (pulsed_act_reg)
				rx_raw_reg <= lines[0] & line_tx_out; // [R10] [R11]
			else
				rx_raw_reg <= lines[sel_used]; // [R4] [R6]
			rx_prev_reg <= rx_raw_reg;
			if (rx_fall)
				hold_cnt_reg <= 5'd16; // [R9]
			else if (tick && hold_cnt_reg != 5'h00)
				hold_cnt_reg <= hold_cnt_reg - 5'h01;
			if (sample_pt)
				rx_sample_reg <= rx_level;
		end
	end

	// Frame sequencing, transmission and arbitration
	always @(posedge clk_sys_in) begin
		if (reset_in) begin
			div_act_reg    <= 4'h0;
			sel_act_reg    <= 2'h0;
			pulsed_act_reg <= 1'b0;
			type_act_reg   <= `TYPE_AUTONOMOUS;
			best_reg       <= 2'h0;
			state_reg      <= ST_IDLE;
			rec_cnt_reg    <= 8'h00;
			ts_cnt_reg     <= 4'h0;
			gp_reg         <= 2'h0;
			half_reg       <= 1'b0;
			tx_bit_reg     <= 1'b1;
			tx_active_reg  <= 1'b0;
			tx_pending_reg <= 1'b0;
			sync_armed_reg <= 1'b0;
			tx_shift_reg   <= 32'h00000000;
			tx_left_reg    <= 6'h00;
			rx_shift_reg   <= 32'h00000000;
			rx_cnt_reg     <= 6'h00;
			rx_data_reg    <= 32'h00000000;
			rx_count_reg   <= 6'h00;
			arb_lost_reg   <= 1'b0;
			tx_done_reg    <= 1'b0;
			rx_done_reg    <= 1'b0;
		end else begin
			if (wr_stat) begin
				arb_lost_reg <= arb_lost_reg & ~pwdata_in[`ST_ARB_BIT];
				tx_done_reg  <= tx_done_reg & ~pwdata_in[`ST_TXDONE_BIT];
				rx_done_reg  <= rx_done_reg & ~pwdata_in[`ST_RXDONE_BIT];
			end
			if (abort_cmd && !tx_active_reg)
				tx_pending_reg <= 1'b0;
			if (start_cmd && !tx_active_reg)
				tx_pending_reg <= 1'b1;
			if (state_reg == ST_IDLE) begin
				div_act_reg    <= ctrl_reg[`CTRL_DIV_LSB +: 4]; // [R21]
				sel_act_reg    <= ctrl_reg[`CTRL_SEL_LSB +: 2]; // [R21]
				pulsed_act_reg <= ctrl_reg[`CTRL_PULSED_BIT]; // [R21]
				type_act_reg   <= ctrl_reg[`CTRL_TYPE_LSB +: 2]; // [R21]
				if (err_all[7:0] <= err_all[15:8] && err_all[7:0] <= err_all[23:16])
					best_reg <= 2'h0; // [R5]
				else if (err_all[15:8] <= err_all[23:16])
					best_reg <= 2'h1;
				else
					best_reg <= 2'h2;
			end
			if (ts_end) begin
				if (rx_sample_reg && rec_cnt_reg != 8'hff)
					rec_cnt_reg <= rec_cnt_reg + 8'h01; // [R18]
				else if (!rx_sample_reg)
					rec_cnt_reg <= 8'h00;
			end
			case (state_reg)
			ST_IDLE: begin
				if (tx_pending_reg && bus_free && type_act_reg == `TYPE_SYNC)
					sync_armed_reg <= 1'b1; // [R20]
				if (rx_fall) begin
					state_reg  <= ST_SOF_RX; // [R19]
					ts_cnt_reg <= 4'h0;
				end else if (ts_end && tx_pending_reg && bus_free && type_act_reg == `TYPE_AUTONOMOUS) begin
					state_reg  <= ST_SOF_TX; // [R14] [R18] [R20]
					ts_cnt_reg <= 4'h0;
					tx_bit_reg <= sof_pattern[`SOF_TS - 1]; // [R13]
				end
			end
			ST_SOF_TX, ST_SOF_RX: begin
				if (ts_end) begin
					ts_cnt_reg <= ts_cnt_reg + 4'h1;
					if (ts_cnt_reg == `SOF_TS - 1) begin
						state_reg     <= ST_FRAME; // [R16]
						gp_reg        <= 2'h0;
						half_reg      <= 1'b0;
						rx_cnt_reg    <= 6'h00;
						tx_shift_reg  <= tx_data_reg;
						tx_left_reg   <= tx_len_reg;
						// Sync modules start only if they saw the bus free first
						tx_active_reg <= tx_pending_reg && tx_len_reg != 6'h00 &&
						                 (type_act_reg != `TYPE_SYNC || sync_armed_reg); // [R14] [R20]
						tx_bit_reg    <= !(tx_pending_reg && tx_len_reg != 6'h00 &&
						                   (type_act_reg != `TYPE_SYNC || sync_armed_reg)) | tx_data_reg[31];
					end else if (state_reg == ST_SOF_TX) begin
						tx_bit_reg <= sof_pattern[`SOF_TS - 2 - ts_cnt_reg]; // [R13]
					end
				end
			end
			ST_FRAME: begin
				if (ts_end) begin
					if (data_slot && rx_cnt_reg != 6'h3f) begin
						rx_shift_reg <= {rx_shift_reg[30:0], rx_sample_reg}; // [R17]
						rx_cnt_reg   <= rx_cnt_reg + 6'h01;
					end
					if (gp_reg == 2'h3 && !half_reg) begin
						half_reg <= 1'b1; // [R17]
					end else begin
						half_reg <= 1'b0;
						gp_reg   <= gp_reg + 2'h1; // [R17]
					end
					if (eof_seen) begin
						state_reg      <= ST_IDLE;
						rx_data_reg    <= rx_shift_reg;
						rx_count_reg   <= rx_cnt_reg;
						rx_done_reg    <= 1'b1;
						tx_active_reg  <= 1'b0;
						tx_bit_reg     <= 1'b1;
						sync_armed_reg <= 1'b0;
					end else if (tx_active_reg) begin
						if (tx_bit_reg && !rx_sample_reg) begin
							// Losing keeps the request pending for the next free bus
							tx_active_reg <= 1'b0; // [R7]
							tx_bit_reg    <= 1'b1; // [R7]
							arb_lost_reg  <= 1'b1; // [R7]
						end else if (!data_slot) begin
							tx_bit_reg <= ~tx_bit_reg; // [R17]
						end else if (tx_left_reg == 6'h01) begin
							tx_active_reg  <= 1'b0;
							tx_bit_reg     <= 1'b1;
							tx_done_reg    <= 1'b1;
							tx_pending_reg <= start_cmd;
							sync_armed_reg <= 1'b0;
						end else begin
							tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
							tx_left_reg  <= tx_left_reg - 6'h01;
							tx_bit_reg   <= tx_shift_reg[30];
						end
					end
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule

/* File: core/van_line_consts.vh */
// Purpose: constants for the line bit timing block
// Assumes: APB byte addresses, 32-bit data
// Notes:   timing counts are in prescaled clocks or timeslots
`ifndef VAN_LINE_CONSTS_VH
`define VAN_LINE_CONSTS_VH

`define OFS_CTRL        8'h00
`define OFS_CMD         8'h04
`define OFS_TX_DATA     8'h08
`define OFS_TX_LEN      8'h0c
`define OFS_STATUS      8'h10
`define OFS_RX_DATA     8'h14
`define OFS_RX_COUNT    8'h18
`define OFS_DIAG        8'h1c

`define CTRL_DIV_LSB    0
`define CTRL_SEL_LSB    4
`define CTRL_PULSED_BIT 6
`define CTRL_TYPE_LSB   7
`define CTRL_RESET      9'h000
`define CMD_START_BIT   0
`define CMD_ABORT_BIT   1
`define ST_ARB_BIT      0
`define ST_TXDONE_BIT   1
`define ST_RXDONE_BIT   2

`define SEL_AUTO        2'h3
`define TYPE_AUTONOMOUS 2'h0
`define TYPE_SYNC       2'h1
`define TYPE_SLAVE      2'h2

`define SLOT_TICKS      16
`define SAMPLE_SLOT     4'h8
`define PULSE_TICKS     4'h2
`define IFS_TICKS       64
`define IFS_TS          ((`IFS_TICKS + `SLOT_TICKS - 1) / `SLOT_TICKS)
`define EOF_TS          8
`define SOF_TS          10
`define SOF_PATTERN     10'h0f2
`define MIN_EDGE_TICKS  4'h8

`endif

/* File: dv/van_line_bit_timing_properties.sv */
// Purpose: port checker for the VAN line layer
// Assumes: one clock domain, synchronous active-high reset
// Notes:   APB answers in the cycle after setup
`timescale 1ns/1ps
module van_line_bit_timing_properties (
	input wire        clk_sys_in,
	input wire        reset_in,
	input wire        psel_in,
	input wire        penable_in,
	input wire        pwrite_in,
	input wire [7:0]  paddr_in,
	input wire [31:0] prdata_out,
	input wire        pready_out,
	input wire        pslverr_out,
	input wire        osc_in,
	input wire        osc_drive_out,
	input wire        buffered_clock_out,
	input wire        timeslot_clock_out,
	input wire        line_tx_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);
	wire setup = psel_in && !penable_in;
	AST_BUFFERED_CLOCK_OUT_COPY: assert property (1'b1 |=> buffered_clock_out == $past(osc_in))
		else $error("clock output is not a copy of osc");
	AST_DRIVE_INV: assert property (1'b1 |=> osc_drive_out == !$past(osc_in))
		else $error("osc drive is not inverted");
	AST_READY_AFTER_SETUP: assert property (setup |=> pready_out)
		else $error("no ready after setup");
	AST_READY_ONLY_ACCESS: assert property (pready_out |-> $past(setup))
		else $error("ready outside access");
	AST_UNALIGNED: assert property (setup && !pwrite_in && paddr_in[1:0] != 2'h0 |=> pslverr_out && prdata_out == 32'h0)
		else $error("unaligned read not refused");
	AST_UNMAPPED: assert property (setup && paddr_in > 8'h1c |=> pslverr_out)
		else $error("unmapped access not refused");
	AST_CMD_READS_ZERO: assert property (setup && !pwrite_in && paddr_in == 8'h04 |=> prdata_out == 32'h0 && !pslverr_out)
		else $error("command word read not zero");
	AST_SLOT_SPACING: assert property (timeslot_clock_out |=> !timeslot_clock_out [*8])
		else $error("timeslot pulses too close");
	COV_SLOT: cover property (timeslot_clock_out);
	COV_ERR: cover property (pslverr_out);
	COV_TX_LOW: cover property ($fell(line_tx_out));
endmodule
bind van_line_bit_timing van_line_bit_timing_properties chk (.clk_sys_in, .reset_in, .psel_in, .penable_in,
	.pwrite_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out, .osc_in, .osc_drive_out, .buffered_clock_out,
	.timeslot_clock_out, .line_tx_out);

/* File: dv/van_bus_partner.sv */
// Purpose: bus wire and other bus modules seen by the line layer
// Assumes: all three receive inputs see the same healthy wire
// Notes:   jam stands for another module sending dominant
`timescale 1ns/1ps
module van_bus_partner (
	input  wire dut_tx_in,
	input  wire jam_in,
	output wire line_zero_out,
	output wire line_one_out,
	output wire line_two_out
);
	// Wired-AND: dominant from any driver wins, own data is heard back
	wire bus = dut_tx_in & ~jam_in;
	assign line_zero_out = bus;
	assign line_one_out  = bus;
	assign line_two_out  = bus;
endmodule

/* File: dv/van_line_bit_timing_bench.sv */
// Purpose: self-checking bench for the VAN line layer
// Assumes: osc toggles every clock, so a tick is 2n clocks
// Notes:   the partner jams the bus in the arbitration test and to open a received frame
`timescale 1ns/1ps
`include "van_line_consts.vh"
module van_line_bit_timing_bench;
	reg         clk_sys_in = 1'b0;
	reg         reset_in = 1'b1;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg         osc = 1'b0;
	reg         jam = 1'b0;
	wire [31:0] prdata;
	wire        pready, pslverr, tx, ts, l0, l1, l2;
	reg  [31:0] q, d;
	reg         se;
	integer     errors = 0, n_checks = 0, cyc = 0, i, j, p, c;
	van_line_bit_timing dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .osc_in(osc), .osc_drive_out(), .buffered_clock_out(), .timeslot_clock_out(ts),
		.line_input_zero_in(l0), .line_input_one_in(l1), .line_input_two_in(l2), .line_tx_out(tx));
	van_bus_partner partner (.dut_tx_in(tx), .jam_in(jam), .line_zero_out(l0), .line_one_out(l1), .line_two_out(l2));
	initial begin
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	task close_out;
		begin
			$display("checks %0d errors %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	always @(posedge clk_sys_in) begin
		osc <= ~osc;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors = errors + 1;
			close_out;
		end
	end
	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("Error at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// Setup one edge after entry, so a release never meets a new setup
	task apb(input wr, input [7:0] a, input [31:0] v);
		integer t;
		begin
			@(posedge clk_sys_in);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= v;
			@(posedge clk_sys_in);
			penable <= 1'b1;
			t = 0;
			@(posedge clk_sys_in);
			while (pready !== 1'b1) begin
				@(posedge clk_sys_in);
				t = t + 1;
			end
			q = prdata;
			se = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wait_status(input integer b);
		integer t;
		begin
			t = 0;
			q = 0;
			while (q[b] !== 1'b1 && t < 400) begin
				apb(1'b0, `OFS_STATUS, 32'h0);
				t = t + 1;
			end
		end
	endtask
	task wait_fall;
		integer t;
		begin
			t = 0;
			@(posedge clk_sys_in);
			while (tx !== 1'b0 && t < 3000) begin
				@(posedge clk_sys_in);
				t = t + 1;
			end
			check(tx, 0);
		end
	endtask
	task slot(input [31:0] b);
		begin
			check(tx, b & 1);
			repeat (32) @(posedge clk_sys_in);
		end
	endtask
	task period(output integer n);
		integer t;
		begin
			t = 0;
			@(posedge clk_sys_in);
			while (ts !== 1'b1 && t < 9000) begin
				@(posedge clk_sys_in);
				t = t + 1;
			end
			n = 1;
			@(posedge clk_sys_in);
			while (ts !== 1'b1 && n < 9000) begin
				@(posedge clk_sys_in);
				n = n + 1;
			end
		end
	endtask
	// Clocks per timeslot: 16 ticks of 2n osc changes, one change a clock
	function integer slot_clks(input [3:0] k);
		slot_clks = (k[3] ? 48 : 32) << k[2:0];
	endfunction
	initial begin
		q = $urandom(72756);
		repeat (16) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(posedge clk_sys_in);
		check(tx, 1);
		d = $urandom % 512;
		apb(1'b1, `OFS_CTRL, d);
		apb(1'b0, `OFS_CTRL, 32'h0);
		check(q, d);
		apb(1'b0, 8'h20, 32'h0);
		check(se, 1);
		apb(1'b1, 8'h02, 32'h5);
		check(se, 1);
		apb(1'b0, 8'h06, 32'h0);
		check({se, q}, {1'b1, 32'h0});
		apb(1'b0, `OFS_CMD, 32'h0);
		check({se, q}, {1'b0, 32'h0});
		for (i = 0; i < 5; i = i + 1) begin
			c = (i < 4) ? (i % 2 + 8 * (i / 2)) : ($urandom % 3 + 8 * ($urandom % 2));
			apb(1'b1, `OFS_CTRL, c);
			period(p);
			period(p);
			check(p, slot_clks(c));
		end
		apb(1'b1, `OFS_CTRL, 32'h0);
		d = $urandom;
		apb(1'b1, `OFS_TX_DATA, d);
		apb(1'b1, `OFS_TX_LEN, 32'h8);
		apb(1'b1, `OFS_CMD, 32'h1);
		wait_fall;
		repeat (16) @(posedge clk_sys_in);
		for (j = 9; j >= 0; j = j - 1)
			slot(`SOF_PATTERN >> j);
		for (j = 0; j < 8; j = j + 1) begin
			slot(d[31-j]);
			if (j % 4 == 3)
				slot(~d[31-j]);
		end
		wait_status(`ST_TXDONE_BIT);
		check(q[`ST_ARB_BIT], 0);
		apb(1'b1, `OFS_STATUS, 32'h7);
		apb(1'b1, `OFS_TX_DATA, 32'hffffffff);
		apb(1'b1, `OFS_CMD, 32'h1);
		wait_fall;
		repeat (324) @(posedge clk_sys_in);
		jam <= 1'b1;
		repeat (32) @(posedge clk_sys_in);
		jam <= 1'b0;
		repeat (40) @(posedge clk_sys_in);
		check(tx, 1);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check(q[`ST_ARB_BIT], 1);
		apb(1'b1, `OFS_CMD, 32'h2);
		repeat (600) @(posedge clk_sys_in);
		for (i = 1; i < 3; i = i + 1) begin
			apb(1'b1, `OFS_CTRL, i << `CTRL_TYPE_LSB);
			apb(1'b1, `OFS_CMD, 32'h1);
			p = 0;
			repeat (800) begin
				@(posedge clk_sys_in);
				if (tx === 1'b0)
					p = p + 1;
			end
			check(p, 0);
			apb(1'b1, `OFS_CMD, 32'h2);
		end
		// Another module opens a frame: one dominant timeslot starts reception
		apb(1'b1, `OFS_STATUS, 32'h7);
		jam <= 1'b1;
		repeat (32) @(posedge clk_sys_in);
		jam <= 1'b0;
		apb(1'b0, `OFS_STATUS, 32'h0);
		check(q[10:9], 2);
		wait_status(`ST_RXDONE_BIT);
		check(q[`ST_RXDONE_BIT], 1);
		apb(1'b1, `OFS_CTRL, 1 << `CTRL_PULSED_BIT);
		apb(1'b1, `OFS_STATUS, 32'h7);
		apb(1'b1, `OFS_CMD, 32'h1);
		wait_fall;
		p = 0;
		while (tx === 1'b0 && p < 40) begin
			@(posedge clk_sys_in);
			p = p + 1;
		end
		check(p, 4);
		wait_status(`ST_TXDONE_BIT);
		check(q[`ST_TXDONE_BIT], 1);
		close_out;
	end
endmodule
